// >>> logic/pcr_pad_cfg_regs.sv
// Register bank holding pull-up, slew and drive settings for six control-port pads.
`timescale 1ns/1ns
module pcr_pad_cfg_regs
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clkEn,
    input  wire logic        softRstN,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [15:0] regAddr,
    input  wire logic [15:0] regWrData,
    output logic      [15:0] regRdData,
    output logic             regHit,
    output logic      [5:0]  padPullupEn,
    output logic      [11:0] padSlewSel,
    output logic      [11:0] padDriveSel
);
    // Index order: slave select, slave data-in, master clock, master data,
    // master select, master data-out.
    logic [15:0] cfgQ [pcr_pkg::NUM_REGS];
    logic [5:0]  hitVec;

    genvar gi;
    generate
        for (gi = 0; gi < pcr_pkg::NUM_REGS; gi++)
        begin : g_reg
            // One storage word per pad; soft reset is synchronous so the port keeps working.
            assign hitVec[gi] = (regAddr == pcr_pkg::ADDR_TABLE[gi]);
            always_ff @(posedge clk or posedge sys_rst)
            begin
                if (sys_rst)
                    cfgQ[gi] <= pcr_pkg::RST_TABLE[gi];
                else if (clkEn)
                begin
                    if (!softRstN)
                        cfgQ[gi] <= pcr_pkg::RST_TABLE[gi];
                    else if (regWrEn && hitVec[gi])
                        cfgQ[gi] <= regWrData;
                end
            end
            // Pad controls come straight from the stored word; reserved bits go nowhere.
            assign padPullupEn[gi]         = cfgQ[gi][pcr_pkg::PULL_BIT];
            assign padSlewSel[2*gi +: 2]   = cfgQ[gi][pcr_pkg::SLEW_HI:pcr_pkg::SLEW_LO];
            assign padDriveSel[2*gi +: 2]  = cfgQ[gi][pcr_pkg::DRIVE_HI:pcr_pkg::DRIVE_LO];

            // A landed write moves this pad's pull-up to the written bit.
            property p_pull_follows;
                @(posedge clk) disable iff (sys_rst)
                (clkEn && softRstN && regWrEn && hitVec[gi])
                |=> (padPullupEn[gi] == $past(regWrData[pcr_pkg::PULL_BIT]));
            endproperty
            a_pull_follows: assert property (p_pull_follows) else $error("Pull-up write lost.");

            // Slew field tracks the write into this register only.
            property p_slew_follows;
                @(posedge clk) disable iff (sys_rst)
                (clkEn && softRstN && regWrEn && hitVec[gi])
                |=> (padSlewSel[2*gi +: 2] == $past(regWrData[3:2]));
            endproperty
            a_slew_follows: assert property (p_slew_follows) else $error("Slew write lost.");

            // Drive field tracks the write into this register only.
            property p_drive_follows;
                @(posedge clk) disable iff (sys_rst)
                (clkEn && softRstN && regWrEn && hitVec[gi])
                |=> (padDriveSel[2*gi +: 2] == $past(regWrData[1:0]));
            endproperty
            a_drive_follows: assert property (p_drive_follows) else $error("Drive write lost.");

            // A write to another address must not disturb this word.
            property p_word_holds;
                @(posedge clk) disable iff (sys_rst)
                (clkEn && softRstN && !(regWrEn && hitVec[gi])) |=> $stable(cfgQ[gi]);
            endproperty
            a_word_holds: assert property (p_word_holds) else $error("Stored word moved.");

            // Soft reset reloads this word's default on the next edge.
            property p_word_soft;
                @(posedge clk) disable iff (sys_rst)
                (clkEn && !softRstN) |=> (cfgQ[gi] == pcr_pkg::RST_TABLE[gi]);
            endproperty
            a_word_soft: assert property (p_word_soft) else $error("Soft default wrong.");

            // Leaving hardware reset, the word still holds its documented default.
            property p_word_default;
                @(posedge clk)
                $fell(sys_rst) |-> (cfgQ[gi] == pcr_pkg::RST_TABLE[gi]);
            endproperty
            a_word_default: assert property (p_word_default) else $error("Reset default wrong.");
        end
    endgenerate

    // Hit flag lets the enclosing port tell this bank's addresses from others.
    assign regHit = |hitVec;

    // Read data is registered; unmapped addresses return zero.
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            regRdData <= 16'h0000;
        else if (clkEn && regRdEn)
        begin
            regRdData <= 16'h0000;
            for (int i = 0; i < pcr_pkg::NUM_REGS; i++)
                if (hitVec[i])
                    regRdData <= cfgQ[i];
        end
    end

    // A write lands on the next edge and is visible on the pads right then.
    property p_write_lands;
        @(posedge clk) disable iff (sys_rst)
        (clkEn && softRstN && regWrEn && regAddr == pcr_pkg::ADDR_SS)
        |=> (padPullupEn[0] == $past(regWrData[4])
             && padSlewSel[1:0] == $past(regWrData[3:2])
             && padDriveSel[1:0] == $past(regWrData[1:0]));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("Pad write not applied.");

    property p_soft_reset;
        @(posedge clk) disable iff (sys_rst)
        (clkEn && !softRstN) |=> (padPullupEn == 6'h33 && padSlewSel == 12'hAAA
                                  && padDriveSel == 12'h000);
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("Soft reset defaults wrong.");

    property p_readback;
        @(posedge clk) disable iff (sys_rst)
        (clkEn && regRdEn && !regWrEn && regAddr == pcr_pkg::ADDR_MCLK)
        |=> (regRdData[4] == padPullupEn[2] && regRdData[3:2] == padSlewSel[5:4]);
    endproperty
    a_readback: assert property (p_readback) else $error("Readback mismatch.");

    property p_frozen;
        @(posedge clk) disable iff (sys_rst)
        !clkEn |=> ($stable(padPullupEn) && $stable(padSlewSel) && $stable(padDriveSel));
    endproperty
    a_frozen: assert property (p_frozen) else $error("State moved while disabled.");

    property p_reserved_store;
        @(posedge clk) disable iff (sys_rst)
        (clkEn && softRstN && regWrEn && regAddr == pcr_pkg::ADDR_MDOUT)
        ##1 (clkEn && regRdEn && !regWrEn && regAddr == pcr_pkg::ADDR_MDOUT && softRstN)
        |=> (regRdData[15:5] == $past(regWrData[15:5], 2));
    endproperty
    a_reserved_store: assert property (p_reserved_store) else $error("Reserved bits lost.");

    property p_miss;
        @(posedge clk) disable iff (sys_rst)
        (clkEn && regRdEn && !regHit) |=> (regRdData == 16'h0000);
    endproperty
    a_miss: assert property (p_miss) else $error("Unmapped read not zero.");
endmodule : pcr_pad_cfg_regs

// >>> logic/pcr_pkg.sv
// Constants for the control-port pad configuration register bank.
// Notes on behaviour
// - Slave select/address-0 pad register sits at 0xF79B, resets to 0x0018.
// - Slave data-in/address-1 pad register sits at 0xF79C, resets to 0x0018.
// - Master clock/MP2 pad register sits at 0xF79D, resets to 0x0008.
// - Master data/MP3 pad register sits at 0xF79E, resets to 0x0008.
// - Master select/MP0 pad register sits at 0xF79F, resets to 0x0018.
// - Master data-out/MP1 pad register sits at 0xF7A0, resets to 0x0018.
// - Bit 4 enables the pad pull-up and reads back as written.
// - Bits 3:2 pick slew rate, slowest to fastest, resetting to fast.
// - Bits 1:0 pick drive strength, lowest to highest, resetting to lowest.
// - Bits 15:5 are reserved read/write storage, reset zero, with no pad effect.
// - Soft reset restores defaults and blocks register writes while held; reads still work.
package pcr_pkg;
    localparam int          NUM_REGS   = 6;
    localparam int          ADDR_W     = 16;
    localparam int          DATA_W     = 16;
    localparam logic [15:0] ADDR_SS    = 16'hF79B;
    localparam logic [15:0] ADDR_DIN   = 16'hF79C;
    localparam logic [15:0] ADDR_MCLK  = 16'hF79D;
    localparam logic [15:0] ADDR_MDAT  = 16'hF79E;
    localparam logic [15:0] ADDR_MSEL  = 16'hF79F;
    localparam logic [15:0] ADDR_MDOUT = 16'hF7A0;
    localparam logic [15:0] RST_PULLUP = 16'h0018;
    localparam logic [15:0] RST_NOPULL = 16'h0008;
    localparam int          PULL_BIT   = 4;
    localparam int          SLEW_HI    = 3;
    localparam int          SLEW_LO    = 2;
    localparam int          DRIVE_HI   = 1;
    localparam int          DRIVE_LO   = 0;
    localparam logic [15:0] ADDR_TABLE [NUM_REGS] = '{ADDR_SS, ADDR_DIN, ADDR_MCLK,
                                                      ADDR_MDAT, ADDR_MSEL, ADDR_MDOUT};
    localparam logic [15:0] RST_TABLE  [NUM_REGS] = '{RST_PULLUP, RST_PULLUP, RST_NOPULL,
                                                      RST_NOPULL, RST_PULLUP, RST_PULLUP};
endpackage : pcr_pkg

// >>> tb/test_pcr_pad_cfg_regs.sv
// Self-checking bench for the pad configuration register bank.
`timescale 1ns/1ns
module test_pcr_pad_cfg_regs;
    logic        clk = 1'b0, sysRst = 1'b1, softRstN = 1'b1, wrEn = 1'b0, rdEn = 1'b0;
    logic        clkEn = 1'b1;
    logic [30:0] padSnap;
    logic [15:0] rdSnap;
    logic [15:0] addr = 16'h0000, wrData = 16'h0000, rdData;
    logic [30:0] pads;
    int          badCount = 0, checks = 0;
    pcr_pad_cfg_regs pcr_pad_cfg_regs_i (.clk(clk), .sys_rst(sysRst), .clkEn(clkEn),
        .softRstN(softRstN), .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr), .regWrData(wrData),
        .regRdData(rdData), .regHit(pads[30]), .padPullupEn(pads[29:24]),
        .padSlewSel(pads[23:12]), .padDriveSel(pads[11:0]));
    // Free-running 100 ns clock.
    initial forever #50 clk = ~clk;
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        badCount += int'(got !== exp);
        if (got !== exp) $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
    endtask : cmp
    task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        {wrEn, rdEn, addr, wrData} <= {w, ~w, a, d};
        @(posedge clk);
        {wrEn, rdEn} <= 2'b00;
        #1;
    endtask : acc
    // Each register reads its default, then takes a distinct value so swapped pad slices show.
    task automatic t_regs;
        logic [15:0] d;
        logic [29:0] e = {6'h33, 12'hAAA, 12'h000};
        cmp({1'b0, pads}, {2'b00, e});
        for (int i = 0; i < pcr_pkg::NUM_REGS; i++)
        begin
            acc(1'b0, pcr_pkg::ADDR_TABLE[i], 16'h0000);
            cmp(32'(rdData), 32'(pcr_pkg::RST_TABLE[i]));
            d = 16'hA5E0 | 16'(i * 5);
            acc(1'b1, pcr_pkg::ADDR_TABLE[i], d);
            {e[24 + i], e[12 + 2 * i +: 2], e[2 * i +: 2]} = d[4:0];
            cmp({1'b0, pads}, {2'b01, e});
            acc(1'b0, pcr_pkg::ADDR_TABLE[i], 16'h0000);
            cmp(32'(rdData), 32'(d));
        end
    endtask : t_regs
    // Clock enable low must freeze pads and read data; unmapped accesses change nothing.
    task automatic t_freeze;
        padSnap = pads;
        rdSnap = rdData;
        @(posedge clk);
        clkEn <= 1'b0;
        acc(1'b1, pcr_pkg::ADDR_SS, 16'h001F);
        cmp({1'b0, pads}, {1'b0, padSnap});
        acc(1'b0, pcr_pkg::ADDR_SS, 16'h0000);
        cmp(32'(rdData), 32'(rdSnap));
        @(posedge clk);
        clkEn <= 1'b1;
        acc(1'b1, 16'h0000, 16'hFFFF);
        acc(1'b0, 16'h0000, 16'h0000);
        cmp({1'b0, pads}, {2'b00, padSnap[29:0]});
        cmp(32'(rdData), 32'h0000_0000);
    endtask : t_freeze
    // A write followed at once by a read keeps reserved bits.
    task automatic t_b2b;
        @(posedge clk);
        {wrEn, rdEn, addr, wrData} <= {2'b10, pcr_pkg::ADDR_MDOUT, 16'hFFE5};
        @(posedge clk);
        {wrEn, rdEn} <= 2'b01;
        @(posedge clk);
        rdEn <= 1'b0;
        #1;
        cmp(32'(rdData), 32'h0000_FFE5);
        cmp(32'(pads[29]), 32'h0000_0000);
    endtask : t_b2b
    task automatic t_soft;
        @(posedge clk);
        softRstN <= 1'b0;
        acc(1'b0, pcr_pkg::ADDR_MSEL, 16'h0000);
        cmp(32'(rdData), 32'h0000_0018);
        cmp({1'b0, pads}, {2'b01, 6'h33, 12'hAAA, 12'h000});
    endtask : t_soft
    task automatic test_done;
        if (badCount == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done
    // Reset is held for 16 cycles, then the scenarios run in turn.
    initial
    begin
        repeat (16) @(posedge clk);
        sysRst <= 1'b0;
        t_regs();
        t_freeze();
        t_b2b();
        t_soft();
        test_done();
    end
    // Watchdog: the scenarios need under a hundred cycles, so a hang ends here.
    initial
    begin
        #100000 badCount++;
        test_done();
    end
endmodule : test_pcr_pad_cfg_regs
